// ### rpc_pkg.sv
// Package for the clock page, adjust and reset control block.
// Assumes an AXI4-Lite master with 32-bit data and one aligned word per register.
package rpc_pkg;
  // Byte addresses of the registers
  localparam logic [7:0] RPC_SEC_ADDR = 8'h00;
  localparam logic [7:0] RPC_MIN_ADDR = 8'h04;
  localparam logic [7:0] RPC_YEAR_ADDR = 8'h08;
  localparam logic [7:0] RPC_PAGE_ADDR = 8'h0C;
  localparam logic [7:0] RPC_RESET_ADDR = 8'h10;
  localparam logic [7:0] RPC_ALARM_ADDR = 8'h14;
  // Field positions
  localparam int RPC_PAGE_BIT = 0;
  localparam int RPC_ALM_EN_BIT = 2;
  localparam int RPC_CLK_EN_BIT = 3;
  localparam int RPC_ADJ_BIT = 4;
  localparam int RPC_INT_EN_BIT = 7;
  localparam int RPC_ALM_RST_BIT = 4;
  localparam int RPC_SEC_RST_BIT = 5;
  localparam int RPC_DIS16_BIT = 6;
  localparam int RPC_DIS1_BIT = 7;
  // Reset values
  localparam logic [7:0] RPC_RESET_REG_INIT = 8'hC7;
  localparam logic [6:0] RPC_ALM_INIT = 7'h00;
  // Alarm init: minute 00, hour 01, day 00, weekday Sunday
  localparam logic [31:0] RPC_ALARM_INIT = 32'h0000_0100;
  // Low-speed prescaler: one tick per 1/16 s period in cycles, 16 ticks make a second
  localparam int RPC_TICK16_CYCLES = 16;
  localparam int RPC_TICKS_PER_SEC = 16;
  localparam logic [6:0] RPC_HALF_MIN = 7'h30;
  // AXI responses
  localparam logic [1:0] RPC_RESP_OKAY = 2'b00;
  localparam logic [1:0] RPC_RESP_SLVERR = 2'b10;
  // Interrupt source choice
  typedef enum {SRC_NONE, SRC_ALARM, SRC_1HZ, SRC_16HZ} rpc_src_t;
  // AXI4-Lite request and answer groups
  typedef struct packed {
    logic awvalid; logic [7:0] awaddr; logic wvalid; logic [31:0] wdata;
    logic [3:0] wstrb; logic bready; logic arvalid; logic [7:0] araddr; logic rready;
  } rpc_axi_req_t;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } rpc_axi_rsp_t;
  // Increment a two-digit BCD value
  function automatic logic [7:0] rpc_bcd_inc(input logic [7:0] v);
    rpc_bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction : rpc_bcd_inc
endpackage : rpc_pkg

// ### rpc_axi_slave.sv
// AXI4-Lite slave front end for the control block.
// Assumes one write and one read at most in flight; answers after both AW and W arrive.
`timescale 1ns/10ps
module rpc_axi_slave import rpc_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire rpc_axi_req_t req_in,
  output rpc_axi_rsp_t rsp_out,
  output logic wr_out,
  output logic [7:0] wr_addr_out,
  output logic [7:0] wr_data_out,
  output logic rd_out,
  output logic [7:0] rd_addr_out,
  input wire logic [7:0] rd_data_in,
  input wire logic rd_ok_in,
  input wire logic wr_ok_in
);
  logic aw_held_reg; // Address captured, waiting for data
  logic w_held_reg; // Data captured, waiting for address
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  wire aw_take = req_in.awvalid & rsp_out.awready;
  wire w_take = req_in.wvalid & rsp_out.wready;
  wire both = (aw_held_reg | aw_take) & (w_held_reg | w_take) & ~rsp_out.bvalid;
  wire [7:0] cur_awaddr = aw_take ? req_in.awaddr : awaddr_reg;
  wire [31:0] cur_wdata = w_take ? req_in.wdata : wdata_reg;
  wire [3:0] cur_wstrb = w_take ? req_in.wstrb : wstrb_reg;
  wire ar_take = req_in.arvalid & rsp_out.arready;
  // Only the low byte lane carries register data
  assign wr_out = both & cur_wstrb[0];
  assign wr_addr_out = cur_awaddr;
  assign wr_data_out = cur_wdata[7:0];
  assign rd_out = ar_take;
  assign rd_addr_out = req_in.araddr;

  // Write channel: accept AW and W in either order, answer once both are held
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      aw_held_reg <= 1'b0; w_held_reg <= 1'b0; awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000; wstrb_reg <= 4'h0;
      rsp_out.awready <= 1'b0; rsp_out.wready <= 1'b0;
      rsp_out.bvalid <= 1'b0; rsp_out.bresp <= RPC_RESP_OKAY;
    end else begin
      if (aw_take) awaddr_reg <= req_in.awaddr;
      if (w_take) begin
        wdata_reg <= req_in.wdata;
        wstrb_reg <= req_in.wstrb;
      end
      if (both) begin
        aw_held_reg <= 1'b0; w_held_reg <= 1'b0;
        rsp_out.bvalid <= 1'b1;
        rsp_out.bresp <= wr_ok_in ? RPC_RESP_OKAY : RPC_RESP_SLVERR;
      end else begin
        if (aw_take) aw_held_reg <= 1'b1;
        if (w_take) w_held_reg <= 1'b1;
        if (rsp_out.bvalid && req_in.bready) rsp_out.bvalid <= 1'b0;
      end
      // Ready only while the channel is empty and no answer waits
      rsp_out.awready <= ~(aw_held_reg | aw_take) & ~both & ~rsp_out.bvalid & ~rsp_out.awready;
      rsp_out.wready <= ~(w_held_reg | w_take) & ~both & ~rsp_out.bvalid & ~rsp_out.wready;
    end
  end

  // Read channel: address taken, data one cycle later
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rsp_out.arready <= 1'b0; rsp_out.rvalid <= 1'b0;
      rsp_out.rdata <= 32'h0000_0000; rsp_out.rresp <= RPC_RESP_OKAY;
    end else begin
      rsp_out.arready <= ~rsp_out.rvalid & ~ar_take & ~rsp_out.arready;
      if (ar_take) begin
        rsp_out.rvalid <= 1'b1;
        rsp_out.rdata <= {24'h00_0000, rd_data_in};
        rsp_out.rresp <= rd_ok_in ? RPC_RESP_OKAY : RPC_RESP_SLVERR;
      end else if (rsp_out.rvalid && req_in.rready) begin
        rsp_out.rvalid <= 1'b0;
      end
    end
  end
endmodule : rpc_axi_slave

// ### rpc_ctrl.sv
// Top of the clock page, adjust and reset control block.
// Assumes synchronous inputs on ref_clk_in; the low-speed domain is modelled by an
// internal prescaler tick; the seconds-reset request is sampled at the 16 Hz tick and the adjust request at the one-second step.
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
module rpc_ctrl import rpc_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire rpc_axi_req_t axi_req_in,
  output rpc_axi_rsp_t axi_rsp_out,
  input wire logic alarm_match_in,
  output logic clock_interrupt_request_out,
  output logic [7:0] seconds_out,
  output logic [7:0] minutes_out
);
  logic wr;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic rd;
  logic [7:0] rd_addr;
  logic [7:0] rd_data; // Read mux result toward the bus
  logic rd_ok; // Read address is mapped
  logic wr_ok; // Write address is mapped
  rpc_axi_slave u_bus (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .req_in(axi_req_in),
    .rsp_out(axi_rsp_out),
    .wr_out(wr),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data),
    .rd_out(rd),
    .rd_addr_out(rd_addr),
    .rd_data_in(rd_data),
    .rd_ok_in(rd_ok),
    .wr_ok_in(wr_ok)
  );

  // Control and status state
  logic [7:0] page_control_reg; // Page, enables; bit 4 unused here
  logic adjust_pend_reg; // Posted seconds-adjust request
  logic sec_rst_pend_reg; // Posted seconds-counter reset request
  logic one_hz_disable_reg;
  logic sixteen_hz_disable_reg;
  logic [1:0] leap_reg; // Leap counter
  logic [7:0] year_reg; // Year digits, page zero
  logic [7:0] sec_reg; // BCD seconds
  logic [7:0] min_reg; // BCD minutes
  logic [31:0] alarm_reg; // Weekday, day, hour, minute packed a byte each
  logic [4:0] pre_reg; // Cycle prescaler toward the 16 Hz tick
  logic [3:0] tick_reg; // Sixteen ticks per second

  // Named decode
  wire page1 = page_control_reg[RPC_PAGE_BIT];
  wire clk_en = page_control_reg[RPC_CLK_EN_BIT];
  wire alm_en = page_control_reg[RPC_ALM_EN_BIT];
  wire int_en = page_control_reg[RPC_INT_EN_BIT];
  wire hit_page = wr && wr_addr == RPC_PAGE_ADDR;
  wire hit_reset = wr && wr_addr == RPC_RESET_ADDR;
  wire hit_year = wr && wr_addr == RPC_YEAR_ADDR;
  wire hit_sec = wr && wr_addr == RPC_SEC_ADDR;
  wire hit_min = wr && wr_addr == RPC_MIN_ADDR;
  wire hit_alarm = wr && wr_addr == RPC_ALARM_ADDR;
  function automatic logic rpc_mapped(input logic [7:0] a);
    rpc_mapped = a inside {RPC_SEC_ADDR, RPC_MIN_ADDR, RPC_YEAR_ADDR, RPC_PAGE_ADDR,
                           RPC_RESET_ADDR, RPC_ALARM_ADDR};
  endfunction : rpc_mapped
  assign wr_ok = rpc_mapped(wr_addr);
  assign rd_ok = rpc_mapped(rd_addr);
  // Low-speed ticks: prescaler runs even with the clock disabled
  wire tick16 = pre_reg == 5'(RPC_TICK16_CYCLES - 1);
  wire tick1 = tick16 && tick_reg == 4'(RPC_TICKS_PER_SEC - 1);
  wire sec_step = tick1 && clk_en;
  wire sec_wrap = sec_reg == 8'h59;
  wire adj_go = sec_step && adjust_pend_reg;
  wire adj_carry = sec_reg >= RPC_HALF_MIN;
  wire min_carry = adj_go ? adj_carry : (sec_step && sec_wrap);
  wire [7:0] min_inc = (min_reg == 8'h59) ? 8'h00 : rpc_bcd_inc(min_reg);

  // Interrupt source selection
  wire [2:0] src_sel = {one_hz_disable_reg, sixteen_hz_disable_reg, alm_en};
  // An enum is a two-state type, so it cannot be a net; kept as a variable
  rpc_src_t src;
  assign src = (src_sel == 3'b111) ? SRC_ALARM :
               (src_sel == 3'b010) ? SRC_1HZ :
               (src_sel == 3'b100) ? SRC_16HZ : SRC_NONE;
  wire src_event = (src == SRC_ALARM) ? (alarm_match_in && tick16) :
                   (src == SRC_1HZ) ? tick1 :
                   (src == SRC_16HZ) ? tick16 : 1'b0;
  wire irq_next = int_en && src_event;

  // Read mux
  wire [7:0] page_rd = {int_en, 2'b00, adjust_pend_reg, clk_en, alm_en, 1'b0, page1};
  wire [7:0] reset_rd = {one_hz_disable_reg, sixteen_hz_disable_reg, sec_rst_pend_reg,
                         1'b0, 4'b0111};
  wire [7:0] year_rd = page1 ? {6'b00_0000, leap_reg} : year_reg;
  assign rd_data = (rd_addr == RPC_SEC_ADDR) ? sec_reg :
                   (rd_addr == RPC_MIN_ADDR) ? min_reg :
                   (rd_addr == RPC_YEAR_ADDR) ? year_rd :
                   (rd_addr == RPC_PAGE_ADDR) ? page_rd :
                   (rd_addr == RPC_RESET_ADDR) ? reset_rd :
                   (rd_addr == RPC_ALARM_ADDR) ? alarm_reg[7:0] : 8'h00;

  // Prescaler and sixteenth counter, free running
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pre_reg <= 5'h00;
      tick_reg <= 4'h0;
    end else begin
      pre_reg <= tick16 ? 5'h00 : pre_reg + 5'h01;
      if (tick16) tick_reg <= tick_reg + 4'h1;
    end
  end

  // Page/control register; only defined bits are stored
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      page_control_reg <= 8'h00;
    end else if (hit_page) begin
      page_control_reg <= wr_data & 8'h8D;
    end
  end

  // Adjust request: set by write of one, cleared when acted on; the set wins
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      adjust_pend_reg <= 1'b0;
    end else if (hit_page && wr_data[RPC_ADJ_BIT]) begin
      adjust_pend_reg <= 1'b1;
    end else if (adj_go) begin
      adjust_pend_reg <= 1'b0;
    end
  end

  // Reset register fields and seconds-reset request, taken at the next 16 Hz tick
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      one_hz_disable_reg <= RPC_RESET_REG_INIT[RPC_DIS1_BIT];
      sixteen_hz_disable_reg <= RPC_RESET_REG_INIT[RPC_DIS16_BIT];
      sec_rst_pend_reg <= 1'b0;
    end else begin
      if (hit_reset) begin
        one_hz_disable_reg <= wr_data[RPC_DIS1_BIT];
        sixteen_hz_disable_reg <= wr_data[RPC_DIS16_BIT];
      end
      if (hit_reset && wr_data[RPC_SEC_RST_BIT]) begin
        sec_rst_pend_reg <= 1'b1;
      end else if (tick16) begin
        sec_rst_pend_reg <= 1'b0;
      end
    end
  end

  // Leap counter and year digits share one location
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      leap_reg <= 2'b00;
      year_reg <= 8'h00;
    end else if (hit_year) begin
      if (page1) leap_reg <= wr_data[1:0];
      else year_reg <= wr_data;
    end
  end

  // Alarm registers; reset bit loads the fixed start value
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      alarm_reg <= RPC_ALARM_INIT;
    end else if (hit_reset && wr_data[RPC_ALM_RST_BIT]) begin
      alarm_reg <= RPC_ALARM_INIT;
    end else if (hit_alarm && page1) begin
      alarm_reg <= {alarm_reg[31:8], wr_data};
    end
  end

  // Seconds counter: reset, adjust, count, or software write
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sec_reg <= 8'h00;
    end else if (sec_rst_pend_reg && tick16) begin
      sec_reg <= 8'h00;
    end else if (adj_go) begin
      sec_reg <= 8'h00;
    end else if (sec_step) begin
      sec_reg <= sec_wrap ? 8'h00 : rpc_bcd_inc(sec_reg);
    end else if (hit_sec && !page1) begin
      sec_reg <= {1'b0, wr_data[6:0]};
    end
  end

  // Minutes counter: carried by wrap or by adjust above 29 seconds
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      min_reg <= 8'h00;
    end else if (min_carry) begin
      min_reg <= min_inc;
    end else if (hit_min && !page1) begin
      min_reg <= {1'b0, wr_data[6:0]};
    end
  end

  // Outputs from flip-flops
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clock_interrupt_request_out <= 1'b0;
      seconds_out <= 8'h00;
      minutes_out <= 8'h00;
    end else begin
      clock_interrupt_request_out <= irq_next;
      seconds_out <= sec_reg;
      minutes_out <= min_reg;
    end
  end

  // Checks
  sequence s_adj_posted;
    hit_page && wr_data[RPC_ADJ_BIT];
  endsequence
  a_adjust_read_pending: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    s_adj_posted |=> page_rd[RPC_ADJ_BIT]) else $error("adjust bit not pending");
  a_adjust_waits_tick: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    adjust_pend_reg && !sec_step && !hit_sec && !(sec_rst_pend_reg && tick16) |=> $stable(sec_reg))
    else $error("adjust acted early");
  a_adjust_low_half: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    adj_go && !adj_carry && !hit_min && !(sec_rst_pend_reg && tick16)
    |=> sec_reg == 8'h00 && $stable(min_reg))
    else $error("low-half adjust wrong");
  a_adjust_high_half: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    adj_go && adj_carry |=> min_reg == $past(min_inc) && sec_reg == 8'h00)
    else $error("high-half adjust wrong");
  a_sec_reset_done: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    sec_rst_pend_reg && tick16 && !hit_reset |=> sec_reg == 8'h00 && !sec_rst_pend_reg)
    else $error("seconds reset not done");
  a_alarm_init: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    hit_reset && wr_data[RPC_ALM_RST_BIT] |=> alarm_reg == RPC_ALARM_INIT)
    else $error("alarm not initialised");
  a_irq_gated: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    !$past(int_en) |-> !clock_interrupt_request_out) else $error("irq while disabled");
  a_leap_read: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    page1 |-> year_rd[7:2] == 6'b00_0000) else $error("leap upper bits not zero");
  a_clock_stop: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    !clk_en && !hit_sec && !hit_min && !(sec_rst_pend_reg && tick16) |=> $stable(min_reg))
    else $error("counting while disabled");
  a_src_none: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    src == SRC_NONE |=> !clock_interrupt_request_out) else $error("irq with no source");
endmodule : rpc_ctrl

// ### rpc_ctrl_tb.sv
// Self-checking bench for the clock page, adjust and reset control block.
// Assumes the register map, field positions and prescaler timing held in rpc_pkg.
`timescale 1ns/10ps
module rpc_ctrl_tb import rpc_pkg::*; ;
  logic ref_clk_in = 1'b0; // Bench clock, 125 MHz
  logic rst_b_in = 1'b0; // Held low for three cycles
  rpc_axi_req_t req = '0; // Master side of the register bus
  rpc_axi_rsp_t rsp; // Slave answers
  logic alarm_match_in = 1'b0; // Stands in for the alarm comparator
  logic irq; // Interrupt pulse from the block
  logic [7:0] sec; // BCD seconds
  logic [7:0] mins; // BCD minutes
  int mismatches = 0;
  int comparisons = 0;
  int pulses = 0; // Interrupt pulses seen in a window
  logic [31:0] rd; // Last read data
  logic [1:0] resp; // Last response code
  logic [7:0] s; // Saved seconds value
  logic [3:0] cmb [6] = '{4'hF, 4'hE, 4'h4, 4'h8, 4'hC, 4'h7}; // 1Hz dis, 16Hz dis, alarm, match
  int lo [6] = '{16, 0, 1, 16, 0, 0}; // Fewest pulses in 512 cycles
  int hi [6] = '{64, 0, 3, 64, 0, 0}; // Most pulses in 512 cycles

  rpc_ctrl DUT (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .axi_req_in(req),
    .axi_rsp_out(rsp),
    .alarm_match_in(alarm_match_in),
    .clock_interrupt_request_out(irq),
    .seconds_out(sec),
    .minutes_out(mins)
  );

  // Free-running clock
  initial begin
    forever #4 ref_clk_in = ~ref_clk_in;
  end

  // Count interrupt pulses over n edges; the output stands one cycle, so every edge counts
  task count_irq(input int n);
    pulses = 0;
    repeat (n) begin
      @(posedge ref_clk_in);
      if (irq === 1'b1) pulses++;
    end
  endtask : count_irq

  // Prints the counts and the verdict, then stops
  task print_verdict;
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // Compare two words, four-state exact
  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Bench-side count within a window of expected values
  task check_rng(input int got, input int l, input int h);
    comparisons++;
    if (got < l || got > h) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, l, h);
    end
  endtask : check_rng

  task idle(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask : idle

  // Write one byte; each channel is released at the edge that samples its ready high
  task axi_wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w, ta;
    int n;
    aw = 0; w = 0; n = 0; ta = 0;
    req.awaddr <= a; req.wdata <= {24'h00_0000, d}; req.wstrb <= 4'hF;
    req.awvalid <= 1'b1; req.wvalid <= 1'b1; req.bready <= 1'b1;
    while (!(aw && w) && n < 100) begin
      @(posedge ref_clk_in);
      if (!aw && rsp.awready === 1'b1) begin aw = 1; req.awvalid <= 1'b0; end
      if (!w && rsp.wready === 1'b1) begin w = 1; req.wvalid <= 1'b0; end
      n++;
    end
    // Response follows both halves; bready stays up until it is seen
    while (!ta && n < 200) begin
      @(posedge ref_clk_in);
      if (rsp.bvalid === 1'b1) begin ta = 1; resp = rsp.bresp; end
      n++;
    end
    req.bready <= 1'b0;
    // One edge between transfers so no signal is driven twice in a time step
    @(posedge ref_clk_in);
    if (!ta) begin mismatches++; $display("[ERR] t=%0t got=%h exp=%h", $time, 0, 1); end
  endtask : axi_wr

  // Read one word into rd and resp
  task axi_rd(input logic [7:0] a);
    logic ta;
    int n;
    ta = 0; n = 0;
    req.araddr <= a; req.arvalid <= 1'b1; req.rready <= 1'b1;
    while (!ta && n < 100) begin
      @(posedge ref_clk_in);
      if (rsp.arready === 1'b1) begin ta = 1; req.arvalid <= 1'b0; end
      n++;
    end
    ta = 0;
    while (!ta && n < 200) begin
      @(posedge ref_clk_in);
      if (rsp.rvalid === 1'b1) begin ta = 1; rd = rsp.rdata; resp = rsp.rresp; end
      n++;
    end
    req.rready <= 1'b0;
    @(posedge ref_clk_in);
    if (!ta) begin mismatches++; $display("[ERR] t=%0t got=%h exp=%h", $time, 0, 1); end
  endtask : axi_rd

  // Re-read a register until a status bit drops; bounded by the timeout of 200 reads
  task poll(input logic [7:0] a, input int b);
    int k;
    k = 0;
    axi_rd(a);
    while (rd[b] !== 1'b0 && k < 200) begin axi_rd(a); k++; end
  endtask : poll

  // Main sequence
  initial begin
    int i, k;
    repeat (3) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    @(posedge ref_clk_in);
    axi_rd(RPC_RESET_ADDR); check(rd, 32'h0000_00C7);
    axi_rd(RPC_PAGE_ADDR); check(rd, 32'h0000_0000);
    // Unmapped places answer with an error and no data
    axi_rd(8'h40); check({rd[31:2], resp}, {30'h0000_0000, RPC_RESP_SLVERR});
    axi_wr(8'h44, 8'h55); check({30'h0000_0000, resp}, {30'h0000_0000, RPC_RESP_SLVERR});
    axi_wr(RPC_PAGE_ADDR, 8'h62); axi_rd(RPC_PAGE_ADDR); check(rd, 32'h0000_0000);
    axi_wr(RPC_RESET_ADDR, 8'hCF); axi_rd(RPC_RESET_ADDR); check(rd, 32'h0000_00C7);
    // Page one swaps the year place for the leap counter
    axi_wr(RPC_PAGE_ADDR, 8'h01);
    axi_wr(RPC_YEAR_ADDR, 8'hFF); axi_rd(RPC_YEAR_ADDR); check(rd, 32'h0000_0003);
    axi_wr(RPC_YEAR_ADDR, 8'h02); axi_rd(RPC_YEAR_ADDR); check(rd, 32'h0000_0002);
    axi_wr(RPC_ALARM_ADDR, 8'h45); axi_wr(RPC_RESET_ADDR, 8'hD7);
    axi_rd(RPC_ALARM_ADDR); check({24'h00_0000, rd[7:0]}, 32'h0000_0000);
    // Seconds reset: let the clock run first so there is something to clear
    axi_wr(RPC_PAGE_ADDR, 8'h08); idle(600);
    check({31'h0000_0000, sec !== 8'h00}, 32'h0000_0001);
    axi_wr(RPC_RESET_ADDR, 8'hE7); poll(RPC_RESET_ADDR, 5); check(rd[5], 1'b0);
    check(sec, 8'h00);
    // Clock disabled: the count must hold
    axi_wr(RPC_PAGE_ADDR, 8'h00); idle(2); s = sec; idle(600); check(sec, s);
    // Adjust at both sides of the half-minute boundary
    for (i = 0; i < 2; i++) begin
      axi_wr(RPC_PAGE_ADDR, 8'h08); axi_wr(RPC_MIN_ADDR, 8'h10);
      s = sec; k = 0;
      // Start just after a step so the next one is a full second away
      while (sec === s && k < 400) begin @(posedge ref_clk_in); k++; end
      axi_wr(RPC_SEC_ADDR, i ? 8'h30 : 8'h29);
      axi_wr(RPC_PAGE_ADDR, 8'h18);
      axi_rd(RPC_PAGE_ADDR); check(rd, 32'h0000_0018);
      check(sec, i ? 8'h30 : 8'h29);
      poll(RPC_PAGE_ADDR, 4); check(rd, 32'h0000_0008);
      check(sec, 8'h00);
      check(mins, i ? 8'h11 : 8'h10);
    end
    // Six interrupt source combinations covering every source, each first with the gate closed
    for (i = 0; i < 6; i++) begin
      alarm_match_in <= cmb[i][0];
      axi_wr(RPC_PAGE_ADDR, {5'h01, cmb[i][1], 2'h0});
      axi_wr(RPC_RESET_ADDR, {cmb[i][3], cmb[i][2], 6'h07});
      count_irq(256); check_rng(pulses, 0, 0);
      axi_wr(RPC_PAGE_ADDR, {5'h11, cmb[i][1], 2'h0});
      count_irq(512); check_rng(pulses, lo[i], hi[i]);
      axi_wr(RPC_PAGE_ADDR, {5'h01, cmb[i][1], 2'h0});
    end
    print_verdict();
  end

  // Watchdog well beyond the roughly seven thousand cycles the sequence needs
  initial begin
    repeat (40000) @(posedge ref_clk_in);
    mismatches++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1, 0);
    print_verdict();
  end
endmodule : rpc_ctrl_tb
